//--- verilog/tmr_compare_output.sv
// 8-bit timer counter with compare match output unit, channel A
//
// Function
// - Output mode field picks match action and whether the timer drives the pin.
// - Reset clears the internal output state to zero.
// - Nonzero output mode overrides port data on the pin, any waveform mode.
// - Output state can be preset before the pin override is enabled.
// - Output mode zero leaves the output state unchanged at a match.
// - A new output mode acts at the first match after the write.
// - In non-PWM modes the force strobe applies the action at once.
// - Waveform mode sets the counting sequence; output mode never does.
// - PWM modes: inverted or not, or toggle at match in mode 7; non-PWM: set, clear or toggle at match.
// - Normal mode only increments, wrapping from 0xFF to 0x00.
// - Normal mode sets overflow flag as counter turns zero; never clears it.
// - Overflow interrupt execution clears the overflow flag.
// - Counter may be written anytime in normal mode.
// - Clear-on-compare mode clears counter when it equals compare value A.
// - Clear-on-compare mode raises compare flag A at each top.
// - Compare A is unbuffered there; a missed match runs through 0xFF wrap.
// - Output mode 1 toggles state at each match; compare 0x00 gives two clocks.
// - Toggle interval is N times (1 plus compare A) clocks.
// - Clear-on-compare sets overflow flag when passing max to 0x00.
// - Fast PWM modes 3 and 7 count single slope; top 0xFF or compare A.
// - Fast PWM non-inverting clears at match, sets at bottom; inverting opposite.
// - Compare match flag set on the timer clock after counter equals compare.
`timescale 1ns/1ps
`default_nettype none
module tmr_compare_output (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    // Register port
    input  wire logic [tmr_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [7:0]                  regWrData,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    output logic      [7:0]                  regRdData,
    // Interrupt execution acknowledges
    input  wire logic                        ovfIntAck,
    input  wire logic                        cmpIntAckA,
    // Flags seen by the interrupt controller
    output logic                             overflowFlag,
    output logic                             compareMatchFlagA,
    // Port pin
    input  wire logic                        portDataBit,
    input  wire logic                        comparePinDirectionBit,
    output logic                             pinOut,
    output logic                             pinOe_n
);
    import tmr_pkg::*;

    tmr_state_t stateFf;
    tmr_state_t nxtState;
    logic       timerTick;

    ////////////////////////////////////////////////////////////////////////
    // Timer clock enable

    tmr_prescaler u_prescaler (
        .core_clk  (core_clk),
        .rst       (rst),
        .clkSel    (stateFf.clkSel),
        .timerTick (timerTick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decodes

    function automatic logic isFastPwm(input logic [2:0] wgm);
        return (wgm == WGM_FAST_MAX) || (wgm == WGM_FAST_CMP);
    endfunction

    function automatic logic wrHit(input logic wr, input logic [ADDR_W-1:0] a,
                                   input logic [3:0] ofs);
        return wr && (a == ofs);
    endfunction

    logic       wrCtrlA;
    logic       wrCtrlB;
    logic       wrCount;
    logic       wrCmpA;
    logic       wrFlags;
    logic       wrOutState;
    logic       fastPwm;
    logic       matchA;
    logic       atTop;
    logic       clearsAtTop;
    logic       forceA;
    logic [7:0] rdMux;

    always_comb begin
        wrCtrlA    = wrHit(regWr, regAddr, OFS_CTRL_A);
        wrCtrlB    = wrHit(regWr, regAddr, OFS_CTRL_B);
        wrCount    = wrHit(regWr, regAddr, OFS_COUNT);
        wrCmpA     = wrHit(regWr, regAddr, OFS_CMP_A);
        wrFlags    = wrHit(regWr, regAddr, OFS_FLAGS);
        wrOutState = wrHit(regWr, regAddr, OFS_OUTSTATE);
        fastPwm    = isFastPwm(stateFf.wgm);
        // Compare A is live, not double buffered, so a late lower value is missed
        matchA     = (stateFf.count == stateFf.cmpA);
        // Top depends only on the waveform mode, never on the output mode
        case (stateFf.wgm)
            WGM_CTC:      atTop = matchA;
            WGM_FAST_CMP: atTop = matchA;
            WGM_FAST_MAX: atTop = (stateFf.count == CNT_MAX);
            default:      atTop = (stateFf.count == CNT_MAX);
        endcase
        clearsAtTop = (stateFf.wgm != WGM_NORMAL) && atTop;
        forceA      = wrCtrlB && regWrData[FORCE_A_BIT] && !fastPwm;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux

    always_comb begin
        case (regAddr)
            OFS_CTRL_A:   rdMux = {stateFf.comA, 4'h0, stateFf.wgm[WGM_LO_HI:0]};
            OFS_CTRL_B:   rdMux = {4'h0, stateFf.wgm[2], stateFf.clkSel};
            OFS_COUNT:    rdMux = stateFf.count;
            OFS_CMP_A:    rdMux = stateFf.cmpA;
            OFS_FLAGS:    rdMux = {6'h00, stateFf.cmpFlagA, stateFf.ovfFlag};
            OFS_OUTSTATE: rdMux = {7'h00, stateFf.outStateA};
            default:      rdMux = RD_ZERO;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxtState = stateFf;

        // Configuration; a new output mode only acts at later matches
        if (wrCtrlA) begin
            nxtState.comA           = regWrData[COM_A_HI:COM_A_LO];
            nxtState.wgm[WGM_LO_HI:0] = regWrData[WGM_LO_HI:0];
        end
        if (wrCtrlB) begin
            nxtState.wgm[2] = regWrData[WGM_HI_BIT];
            nxtState.clkSel = regWrData[CLKSEL_HI:0];
        end
        if (wrCmpA) begin
            nxtState.cmpA = regWrData;
        end

        // Counting sequence
        if (timerTick) begin
            if (clearsAtTop) begin
                nxtState.count = CNT_BOTTOM;
            end else begin
                nxtState.count = stateFf.count + 8'h01;
            end
        end
        // A software write to the counter beats the count
        if (wrCount) begin
            nxtState.count = regWrData;
        end

        // Flags: software write of one clears, interrupt ack clears, set wins
        if ((wrFlags && regWrData[FLAG_OVF_BIT]) || ovfIntAck) begin
            nxtState.ovfFlag = 1'b0;
        end
        if ((wrFlags && regWrData[FLAG_CMP_BIT]) || cmpIntAckA) begin
            nxtState.cmpFlagA = 1'b0;
        end
        if (timerTick && (stateFf.count == CNT_MAX) && !fastPwm) begin
            nxtState.ovfFlag = 1'b1;
        end
        if (timerTick && fastPwm && atTop) begin
            nxtState.ovfFlag = 1'b1;
        end
        if (timerTick && matchA) begin
            nxtState.cmpFlagA = 1'b1;
        end

        // Output state actions
        if (timerTick && matchA && !fastPwm) begin
            case (stateFf.comA)
                COM_TOGGLE: nxtState.outStateA = !stateFf.outStateA;
                COM_CLEAR:  nxtState.outStateA = 1'b0;
                COM_SET:    nxtState.outStateA = 1'b1;
                default:    nxtState.outStateA = stateFf.outStateA;
            endcase
        end
        if (timerTick && fastPwm) begin
            case (stateFf.comA)
                COM_TOGGLE: begin
                    if (matchA && stateFf.wgm[2]) begin
                        nxtState.outStateA = !stateFf.outStateA;
                    end
                end
                COM_CLEAR: begin
                    if (matchA) begin
                        nxtState.outStateA = 1'b0;
                    end
                    // Bottom wins so a compare at top gives a constant level
                    if (atTop) begin
                        nxtState.outStateA = 1'b1;
                    end
                end
                COM_SET: begin
                    if (matchA) begin
                        nxtState.outStateA = 1'b1;
                    end
                    if (atTop) begin
                        nxtState.outStateA = 1'b0;
                    end
                end
                default: nxtState.outStateA = stateFf.outStateA;
            endcase
        end
        if (forceA) begin
            case (stateFf.comA)
                COM_TOGGLE: nxtState.outStateA = !stateFf.outStateA;
                COM_CLEAR:  nxtState.outStateA = 1'b0;
                COM_SET:    nxtState.outStateA = 1'b1;
                default:    nxtState.outStateA = stateFf.outStateA;
            endcase
        end
        // Direct preset so the pin starts from a known level
        if (wrOutState) begin
            nxtState.outStateA = regWrData[0];
        end

        nxtState.rdData = regRd ? rdMux : RD_ZERO;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stateFf <= '0;
        end else begin
            stateFf <= nxtState;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs and pin override

    logic overrideOn;

    always_comb begin
        overrideOn = (stateFf.comA != COM_OFF);
        pinOut     = overrideOn ? stateFf.outStateA : portDataBit;
        pinOe_n    = !comparePinDirectionBit;
    end

    assign regRdData         = stateFf.rdData;
    assign overflowFlag      = stateFf.ovfFlag;
    assign compareMatchFlagA = stateFf.cmpFlagA;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_quietTick;
        timerTick && !regWr;
    endsequence

    sequence s_fastTop;
        s_quietTick ##0 fastPwm && atTop && !matchA;
    endsequence

    a_reset_clears_state: assert property (disable iff (1'b0) rst |=> !stateFf.outStateA)
        else $error("output state not cleared by reset");

    a_pin_override: assert property (overrideOn |-> pinOut == stateFf.outStateA)
        else $error("pin does not follow output state under override");

    a_port_passthru: assert property (!overrideOn |-> pinOut == portDataBit)
        else $error("port data not on pin without override");

    a_direction_kept: assert property (pinOe_n == !comparePinDirectionBit)
        else $error("pin enable not following direction bit");

    a_normal_wrap: assert property (
        s_quietTick ##0 (stateFf.wgm == WGM_NORMAL) && (stateFf.count == CNT_MAX)
        |=> (stateFf.count == CNT_BOTTOM) && stateFf.ovfFlag)
        else $error("normal mode wrap or overflow wrong");

    a_ovf_sticky: assert property (
        stateFf.ovfFlag && !ovfIntAck && !regWr |=> stateFf.ovfFlag)
        else $error("overflow flag lost without clear");

    a_ovf_ack: assert property (
        ovfIntAck && !timerTick |=> !stateFf.ovfFlag)
        else $error("overflow flag not cleared by interrupt");

    a_ctc_clear: assert property (
        s_quietTick ##0 (stateFf.wgm == WGM_CTC) && matchA
        |=> (stateFf.count == CNT_BOTTOM) && stateFf.cmpFlagA)
        else $error("counter not cleared at compare top");

    a_match_flag: assert property (
        timerTick && matchA && !cmpIntAckA |=> stateFf.cmpFlagA)
        else $error("compare flag not set after match");

    a_count_write: assert property (
        wrCount |=> stateFf.count == $past(regWrData))
        else $error("counter write not taken");

    a_toggle_match: assert property (
        s_quietTick ##0 matchA && !fastPwm && (stateFf.comA == COM_TOGGLE)
        |=> stateFf.outStateA != $past(stateFf.outStateA))
        else $error("output state did not toggle at match");

    a_mode_off_hold: assert property (
        (stateFf.comA == COM_OFF) && !regWr |=> $stable(stateFf.outStateA))
        else $error("output state moved with mode off");

    a_fast_bottom: assert property (
        s_fastTop ##0 (stateFf.comA == COM_CLEAR) |=> stateFf.outStateA ##1 1'b1)
        else $error("fast pwm output not set at bottom");

    a_force_clear: assert property (
        forceA && (stateFf.comA == COM_CLEAR) |=> !stateFf.outStateA)
        else $error("force strobe did not clear output state");

    a_ctc_missed_match: assert property (
        s_quietTick ##0 (stateFf.wgm == WGM_CTC) && !matchA
        |=> stateFf.count == $past(stateFf.count) + 8'h01)
        else $error("counter did not run on past a missed compare");

    a_ctc_overflow: assert property (
        s_quietTick ##0 (stateFf.wgm == WGM_CTC) && (stateFf.count == CNT_MAX)
        |=> stateFf.ovfFlag && (stateFf.count == CNT_BOTTOM))
        else $error("overflow flag not set on compare mode wrap");

    a_fast_top_wrap: assert property (s_fastTop |=> stateFf.count == CNT_BOTTOM)
        else $error("fast pwm counter did not restart at top");

    a_fast_match_clear: assert property (
        s_quietTick ##0 fastPwm && matchA && !atTop && (stateFf.comA == COM_CLEAR)
        |=> !stateFf.outStateA)
        else $error("fast pwm output not cleared at match");

endmodule
`default_nettype wire

//--- verilog/tmr_pkg.sv
// Shared constants and state type of the 8-bit timer compare output block
package tmr_pkg;

    // Register indices on the plain register port
    localparam int          ADDR_W       = 4;
    localparam logic [3:0]  OFS_CTRL_A   = 4'h0;
    localparam logic [3:0]  OFS_CTRL_B   = 4'h1;
    localparam logic [3:0]  OFS_COUNT    = 4'h2;
    localparam logic [3:0]  OFS_CMP_A    = 4'h3;
    localparam logic [3:0]  OFS_FLAGS    = 4'h4;
    localparam logic [3:0]  OFS_OUTSTATE = 4'h5;

    // Field positions
    localparam int          COM_A_HI     = 7;
    localparam int          COM_A_LO     = 6;
    localparam int          WGM_LO_HI    = 1;
    localparam int          FORCE_A_BIT  = 7;
    localparam int          WGM_HI_BIT   = 3;
    localparam int          CLKSEL_HI    = 2;
    localparam int          FLAG_CMP_BIT = 1;
    localparam int          FLAG_OVF_BIT = 0;

    // Counter extremes and the value read back when idle
    localparam logic [7:0]  CNT_BOTTOM   = 8'h00;
    localparam logic [7:0]  CNT_MAX      = 8'hFF;
    localparam logic [7:0]  RD_ZERO      = 8'h00;

    // Waveform modes handled here
    localparam logic [2:0]  WGM_NORMAL   = 3'h0;
    localparam logic [2:0]  WGM_CTC      = 3'h2;
    localparam logic [2:0]  WGM_FAST_MAX = 3'h3;
    localparam logic [2:0]  WGM_FAST_CMP = 3'h7;

    // Compare output mode encodings
    localparam logic [1:0]  COM_OFF      = 2'h0;
    localparam logic [1:0]  COM_TOGGLE   = 2'h1;
    localparam logic [1:0]  COM_CLEAR    = 2'h2;
    localparam logic [1:0]  COM_SET      = 2'h3;

    // Prescaler selections and their divider masks
    localparam logic [2:0]  CS_STOP      = 3'h0;
    localparam logic [2:0]  CS_DIV1      = 3'h1;
    localparam logic [2:0]  CS_DIV8      = 3'h2;
    localparam logic [2:0]  CS_DIV64     = 3'h3;
    localparam logic [2:0]  CS_DIV256    = 3'h4;
    localparam logic [2:0]  CS_DIV1024   = 3'h5;
    localparam int          PRE_W        = 10;
    localparam logic [9:0]  MASK_DIV1    = 10'h000;
    localparam logic [9:0]  MASK_DIV8    = 10'h007;
    localparam logic [9:0]  MASK_DIV64   = 10'h03F;
    localparam logic [9:0]  MASK_DIV256  = 10'h0FF;
    localparam logic [9:0]  MASK_DIV1024 = 10'h3FF;

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] cmpA;
        logic [1:0] comA;
        logic [2:0] wgm;
        logic [2:0] clkSel;
        logic       ovfFlag;
        logic       cmpFlagA;
        logic       outStateA;
        logic [7:0] rdData;
    } tmr_state_t;

endpackage

//--- verilog/tmr_prescaler.sv
// Prescaler producing the one-cycle timer clock enable
`timescale 1ns/1ps
`default_nettype none
module tmr_prescaler (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    // Selection and enable
    input  wire logic [2:0]                  clkSel,
    output logic                             timerTick
);
    import tmr_pkg::*;

    typedef struct packed {
        logic [PRE_W-1:0] div;
    } tmr_pre_t;

    tmr_pre_t stateFf;
    tmr_pre_t nxtState;
    logic [PRE_W-1:0] mask;
    logic             running;

    always_comb begin
        running = 1'b1;
        case (clkSel)
            CS_DIV1:    mask = MASK_DIV1;
            CS_DIV8:    mask = MASK_DIV8;
            CS_DIV64:   mask = MASK_DIV64;
            CS_DIV256:  mask = MASK_DIV256;
            CS_DIV1024: mask = MASK_DIV1024;
            // External clock sources are not supported: treated as stopped
            default: begin
                mask    = MASK_DIV1;
                running = 1'b0;
            end
        endcase
        nxtState.div = stateFf.div + 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stateFf <= '0;
        end else begin
            stateFf <= nxtState;
        end
    end

    assign timerTick = running && ((stateFf.div & mask) == mask);

endmodule
`default_nettype wire

//--- verif/tmr_pin_load.sv
// Load on the compare output pin: resolves the level seen on the wire
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_load (
    // Clock
    input  wire logic core_clk,
    // Pin from the timer
    input  wire logic pinOut,
    input  wire logic pinOe_n,
    // Level seen on the wire
    output logic      pinLevel
);
    logic lastDrv_ff = 1'b0;

    always_ff @(posedge core_clk) begin
        if (!pinOe_n) begin
            lastDrv_ff <= pinOut;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // No pull on this wire: a released pin must not look like it still holds
    assign pinLevel = !pinOe_n ? pinOut : ~lastDrv_ff;
endmodule
`default_nettype wire

//--- verif/test_timer8_waveform_compare_output.sv
// Self-checking bench of the timer compare output block
`timescale 1ns/1ps
`default_nettype none
module test_timer8_waveform_compare_output;
    import tmr_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [7:0]  regWrData = 8'h00;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [7:0]  regRdData;
    logic        ovfIntAck = 1'b0;
    logic        cmpIntAckA = 1'b0;
    logic        overflowFlag;
    logic        compareMatchFlagA;
    logic        portDataBit = 1'b0;
    logic        comparePinDirectionBit = 1'b0;
    logic        pinOut;
    logic        pinOe_n;
    logic        pinLevel;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          seed;

    tmr_compare_output u_dut (
        .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .ovfIntAck(ovfIntAck),
        .cmpIntAckA(cmpIntAckA), .overflowFlag(overflowFlag),
        .compareMatchFlagA(compareMatchFlagA), .portDataBit(portDataBit),
        .comparePinDirectionBit(comparePinDirectionBit), .pinOut(pinOut), .pinOe_n(pinOe_n)
    );

    tmr_pin_load u_load (
        .core_clk(core_clk), .pinOut(pinOut), .pinOe_n(pinOe_n), .pinLevel(pinLevel)
    );

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge core_clk);
        regWr     <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic chkRd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge core_clk);
        regRd   <= 1'b0;
        @(negedge core_clk);
        check("register", 16'(exp), 16'(regRdData));
    endtask

    task automatic setPin(input logic dir);
        @(posedge core_clk);
        portDataBit            <= 1'($random(seed));
        comparePinDirectionBit <= dir;
    endtask

    // Cycles until the wire level changes, measured from a negedge
    task automatic gap(output int n);
        logic v;
        n = 0;
        v = pinLevel;
        while (pinLevel === v && n < 4000) begin
            @(negedge core_clk);
            n++;
        end
    endtask

    task automatic waitFlag(input bit ovf, input int lim);
        int n;
        n = 0;
        while ((ovf ? overflowFlag : compareMatchFlagA) !== 1'b1 && n < lim) begin
            @(negedge core_clk);
            n++;
        end
    endtask

    function automatic logic nextState(input logic [1:0] com, input logic s);
        case (com)
            COM_TOGGLE: return ~s;
            COM_CLEAR:  return 1'b0;
            COM_SET:    return 1'b1;
            default:    return s;
        endcase
    endfunction

    initial begin
        #200000;
        num_errors++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] r;
        logic       s;
        int         g1;
        int         g2;
        logic [1:0] codes [4] = '{COM_TOGGLE, COM_SET, COM_OFF, COM_CLEAR};
        logic [7:0] cfgA [3] = '{8'h42, 8'h42, 8'h43};
        logic [7:0] cfgB [3] = '{8'h01, 8'h02, 8'h09};
        int         mul [3] = '{1, 8, 1};
        seed = 16765;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) chkRd(4'(i), 8'h00);
        wr(4'hF, 8'hAA);
        chkRd(4'hF, 8'h00);
        r = 8'($random(seed));
        wr(OFS_CMP_A, r);
        chkRd(OFS_CMP_A, r);
        wr(OFS_COUNT, ~r);
        chkRd(OFS_COUNT, ~r);
        // Preset while the port still owns the pin
        setPin(1'b1);
        wr(OFS_OUTSTATE, 8'h01);
        chkRd(OFS_OUTSTATE, 8'h01);
        check("pin port", 16'(portDataBit), 16'(pinLevel));
        wr(OFS_CTRL_A, 8'h40);
        @(negedge core_clk);
        check("pin override", 16'h0001, 16'(pinLevel));
        check("pin enable", 16'h0000, 16'(pinOe_n));
        setPin(1'b0);
        @(negedge core_clk);
        check("pin released", 16'h0001, 16'(pinOe_n));
        setPin(1'b1);
        s = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CTRL_A, {codes[i], 6'h00});
            wr(OFS_CTRL_B, 8'h80);
            s = nextState(codes[i], s);
            chkRd(OFS_OUTSTATE, 8'(s));
        end
        // Normal mode: match flag, overflow, acknowledges
        r = 8'(8 + {$random(seed)} % 240);
        wr(OFS_FLAGS, 8'h03);
        wr(OFS_CMP_A, r);
        wr(OFS_COUNT, r);
        wr(OFS_CTRL_B, 8'h01);
        waitFlag(1'b0, 4);
        check("match flag", 16'h0001, 16'(compareMatchFlagA));
        waitFlag(1'b1, 300);
        check("overflow flag", 16'h0001, 16'(overflowFlag));
        repeat (20) @(negedge core_clk);
        check("overflow sticky", 16'h0001, 16'(overflowFlag));
        // Timer stopped so no match or overflow meets the acknowledge
        wr(OFS_CTRL_B, 8'h00);
        @(posedge core_clk);
        ovfIntAck  <= 1'b1;
        cmpIntAckA <= 1'b1;
        @(posedge core_clk);
        ovfIntAck  <= 1'b0;
        cmpIntAckA <= 1'b0;
        @(negedge core_clk);
        check("overflow ack", 16'h0000, 16'(overflowFlag));
        check("match ack", 16'h0000, 16'(compareMatchFlagA));
        // Toggle intervals: clear-on-compare at two rates, then fast PWM with top A
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CTRL_B, 8'h00);
            wr(OFS_FLAGS, 8'h03);
            r = (i == 0) ? 8'h00 : 8'(2 + {$random(seed)} % 5);
            wr(OFS_CMP_A, r);
            wr(OFS_COUNT, 8'h00);
            wr(OFS_CTRL_A, cfgA[i]);
            wr(OFS_CTRL_B, cfgB[i]);
            gap(g1);
            gap(g1);
            gap(g2);
            check("toggle gap", 16'(mul[i] * (r + 1)), 16'(g1));
            check("toggle gap", 16'(g1), 16'(g2));
            check("top flag", 16'h0001, 16'(compareMatchFlagA));
        end
        // Compare value written below the count: match missed until wrap
        wr(OFS_CTRL_B, 8'h00);
        wr(OFS_CTRL_A, 8'h02);
        wr(OFS_FLAGS, 8'h03);
        wr(OFS_CMP_A, 8'h10);
        wr(OFS_COUNT, 8'h20);
        wr(OFS_CTRL_B, 8'h01);
        repeat (200) @(negedge core_clk);
        check("missed match", 16'h0000, 16'(compareMatchFlagA));
        waitFlag(1'b1, 60);
        check("ctc overflow", 16'h0001, 16'(overflowFlag));
        check("before match", 16'h0000, 16'(compareMatchFlagA));
        waitFlag(1'b0, 30);
        check("late match", 16'h0001, 16'(compareMatchFlagA));
        // Fast PWM with top 0xFF, both polarities
        for (int c = 2; c < 4; c++) begin
            r = 8'(1 + {$random(seed)} % 200);
            wr(OFS_CMP_A, r);
            wr(OFS_CTRL_A, {2'(c), 4'h0, 2'h3});
            wr(OFS_CTRL_B, 8'h01);
            gap(g1);
            gap(g1);
            s = pinLevel;
            gap(g1);
            gap(g2);
            check("pwm period", 16'h0100, 16'(g1 + g2));
            check("pwm high", (c == 2) ? 16'(r + 1) : 16'(255 - r), s ? 16'(g1) : 16'(g2));
        end
        complete_run();
    end
endmodule
`default_nettype wire
